// ===== inc/uac_pkg.sv
package uac_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_FMT      = 8'h00;
  localparam logic [7:0] OFS_PULLUP   = 8'h04;
  localparam logic [7:0] OFS_PULLDN   = 8'h08;
  localparam logic [7:0] OFS_LOOP     = 8'h0C;
  localparam logic [7:0] OFS_TXFLUSH  = 8'h10;
  localparam logic [7:0] OFS_TXLEVEL  = 8'h14;
  localparam logic [7:0] OFS_RXFLUSH  = 8'h18;
  localparam logic [7:0] OFS_RXLEVEL  = 8'h1C;
  localparam logic [7:0] OFS_FWD      = 8'h20;
  localparam logic [7:0] OFS_WIDE     = 8'h24;
  localparam logic [7:0] OFS_GPMASK   = 8'h28;
  localparam logic [7:0] OFS_DRIVER   = 8'h2C;

  // Field positions
  localparam int LOOP_TXRX_BIT = 0;
  localparam int LOOP_RTS_BIT  = 1;
  localparam int LOOP_DTR_BIT  = 2;
  localparam int FLUSH_BIT     = 0;

  // Values after reset
  localparam logic       RST_FMT    = 1'b0;
  localparam logic [7:0] RST_PULL   = 8'h00;
  localparam logic [2:0] RST_LOOP   = 3'h0;
  localparam logic       RST_FWD    = 1'b0;
  localparam logic       RST_WIDE   = 1'b0;
  localparam logic [5:0] RST_GPMASK = 6'h3F;
  localparam logic       RST_DRIVER = 1'b0;

  // Notification header bytes, sent first to last
  localparam logic [7:0]  NOTE_REQ_TYPE = 8'hA1;
  localparam logic [7:0]  NOTE_CODE     = 8'h20;
  localparam logic [15:0] NOTE_VALUE    = 16'h0000;
  localparam logic [15:0] NOTE_INDEX    = 16'h0000;
  localparam logic [15:0] NOTE_LENGTH   = 16'h0002;
  localparam logic [3:0]  NOTE_LAST_IDX = 4'h9;

  // Receive forwarding policy
  localparam logic [23:0] BAUD_LL_LIMIT = 24'h00_A001;
  localparam logic [8:0]  PKT_FULL      = 9'h040;
  localparam logic [8:0]  PKT_FULL_ACM  = 9'h03F;
  localparam logic [1:0]  IDLE_CHARS    = 2'h3;

  typedef enum logic [1:0] {
    UAC_IDLE = 2'b01,
    UAC_SEND = 2'b10
  } uac_state_e;

endpackage

// ===== verilog/uac_sync.sv
module uac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,   // Core clock
  input  wire logic         rst_i,   // Sync reset, high
  input  wire logic [W-1:0] d_i,     // Asynchronous input
  output logic      [W-1:0] q_o      // Filtered level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A bit only moves once the last two stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else begin
      q_o <= (s2_q & s3_q) | (q_o & (s2_q | s3_q));
    end
  end

endmodule // uac_sync

// ===== verilog/uac_top.sv
module uac_top #(
  parameter logic [7:0] TX_DEPTH = 8'h80,
  parameter logic [8:0] RX_DEPTH = 9'h100
) (
  input  wire logic        clk_i,          // Core clock
  input  wire logic        rst_i,          // Sync reset, high
  input  wire logic        wb_cyc_i,       // Bus cycle
  input  wire logic        wb_stb_i,       // Bus strobe
  input  wire logic        wb_we_i,        // Write enable
  input  wire logic [7:0]  wb_adr_i,       // Byte address
  input  wire logic [3:0]  wb_sel_i,       // Byte lanes
  input  wire logic [31:0] wb_dat_i,       // Write data
  output logic      [31:0] wb_dat_o,       // Read data
  output logic             wb_ack_o,       // Acknowledge
  input  wire logic        tx_push_i,      // Char enters tx queue
  input  wire logic        tx_pop_i,       // Char leaves tx queue
  input  wire logic        rx_push_i,      // Char received
  input  wire logic        rx_pop_i,       // Char sent to host
  output logic             tx_flush_o,     // Empty tx queue, pulse
  output logic             rx_flush_o,     // Empty rx queue, pulse
  output logic             rx_drop_o,      // Received char dropped, pulse
  input  wire logic [23:0] baud_rate_i,    // Configured baud rate
  input  wire logic        char_tick_i,    // One per character time
  output logic             rx_forward_o,   // Forward rx data now
  input  wire logic        tx_serial_i,    // Transmitter output
  output logic             tx_pin_o,       // Transmit pin
  input  wire logic        rx_pin_i,       // Receive pin
  output logic             rx_serial_o,    // Receiver input
  input  wire logic        rts_i,          // RTS from flow logic
  input  wire logic        dtr_i,          // DTR from flow logic
  input  wire logic        cts_pin_i,      // CTS pin
  input  wire logic        dsr_pin_i,      // DSR pin
  output logic             cts_o,          // CTS to flow logic
  output logic             dsr_o,          // DSR to flow logic
  input  wire logic [5:0]  gpio_pin_i,     // GPIO pin levels
  input  wire logic        ring_i,         // Ring detect state
  input  wire logic        break_i,        // Break detect state
  input  wire logic        carrier_i,      // Carrier detect state
  input  wire logic        parity_err_i,   // Parity error, pulse
  input  wire logic        framing_err_i,  // Framing error, pulse
  output logic      [7:0]  pullup_en_o,    // Pull-up enables
  output logic      [7:0]  pulldown_en_o,  // Pull-down enables
  output logic             wide_mode_o,    // Wide mode on
  output logic      [7:0]  note_data_o,    // Notification byte
  output logic             note_valid_o,   // Byte valid
  output logic             note_last_o,    // Last byte of packet
  input  wire logic        note_ready_i    // Byte taken
);

  logic       fmt_q;
  logic [7:0] pullup_q;
  logic [7:0] pulldn_q;
  logic [2:0] loop_q;
  logic       fwd_q;
  logic       wide_q;
  logic [5:0] gpmask_q;
  logic       acm_q;
  logic       ack_q;
  logic [31:0] rdat_q;
  logic       tx_flush_q;
  logic       rx_flush_q;
  logic [7:0] tx_cnt_q;
  logic [8:0] rx_cnt_q;
  logic [1:0] idle_cnt_q;
  logic       tx_pin_q;
  logic       rx_ser_q;
  logic       cts_q;
  logic       dsr_q;
  logic       ovr_q;
  logic       par_q;
  logic       frm_q;
  logic [5:0] gpio_prev_q;
  logic [3:0] live_prev_q;
  logic       pend_q;
  logic [79:0] pkt_q;
  logic [3:0] idx_q;
  uac_pkg::uac_state_e state_q;

  logic [2:0]  pins_s;
  logic [5:0]  gpio_s;
  logic        req;
  logic        wr;
  logic        wr_lo;
  logic        capture;
  logic        byte_done;
  logic        rx_drop;
  logic        trigger;
  logic [3:0]  live;
  logic [15:0] status_w;
  logic [8:0]  pkt_size;

  uac_sync #(.W(3)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({rx_pin_i, cts_pin_i, dsr_pin_i}),
    .q_o   (pins_s)
  );

  uac_sync #(.W(6)) u_gpio_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (gpio_pin_i),
    .q_o   (gpio_s)
  );

  // Register bus: one wait state, then a one-cycle ack
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr    = req & wb_we_i & ack_q;
  assign wr_lo = wr & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Unmapped offsets read zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      case (wb_adr_i)
        uac_pkg::OFS_FMT:     rdat_q <= {31'h0000_0000, fmt_q};
        uac_pkg::OFS_PULLUP:  rdat_q <= {24'h00_0000, pullup_q};
        uac_pkg::OFS_PULLDN:  rdat_q <= {24'h00_0000, pulldn_q};
        uac_pkg::OFS_LOOP:    rdat_q <= {29'h0000_0000, loop_q};
        uac_pkg::OFS_TXLEVEL: rdat_q <= {24'h00_0000, tx_cnt_q};
        uac_pkg::OFS_RXLEVEL: rdat_q <= {23'h00_0000, rx_cnt_q};
        uac_pkg::OFS_FWD:     rdat_q <= {31'h0000_0000, fwd_q};
        uac_pkg::OFS_WIDE:    rdat_q <= {31'h0000_0000, wide_q};
        uac_pkg::OFS_GPMASK:  rdat_q <= {26'h000_0000, gpmask_q};
        uac_pkg::OFS_DRIVER:  rdat_q <= {31'h0000_0000, acm_q};
        default:              rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Reserved bits are dropped on write and read back as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt_q    <= uac_pkg::RST_FMT;
      pullup_q <= uac_pkg::RST_PULL;
      pulldn_q <= uac_pkg::RST_PULL;
      loop_q   <= uac_pkg::RST_LOOP;
      wide_q   <= uac_pkg::RST_WIDE;
      gpmask_q <= uac_pkg::RST_GPMASK;
      acm_q    <= uac_pkg::RST_DRIVER;
    end else if (wr_lo) begin
      case (wb_adr_i)
        uac_pkg::OFS_FMT:    fmt_q    <= wb_dat_i[0];
        uac_pkg::OFS_PULLUP: pullup_q <= wb_dat_i[7:0];
        uac_pkg::OFS_PULLDN: pulldn_q <= wb_dat_i[7:0];
        uac_pkg::OFS_LOOP:   loop_q   <= wb_dat_i[2:0];
        uac_pkg::OFS_WIDE:   wide_q   <= wb_dat_i[0];
        uac_pkg::OFS_GPMASK: gpmask_q <= wb_dat_i[5:0];
        uac_pkg::OFS_DRIVER: acm_q    <= wb_dat_i[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_q <= uac_pkg::RST_FWD;
    end else if (baud_rate_i < uac_pkg::BAUD_LL_LIMIT) begin
      fwd_q <= 1'b1;
    end else if (wr_lo && wb_adr_i == uac_pkg::OFS_FWD) begin
      fwd_q <= wb_dat_i[0];
    end
  end

  assign pullup_en_o   = pullup_q;
  // Pull-down drive; both set on one pin is left to software
  assign pulldown_en_o = pulldn_q;
  assign wide_mode_o   = wide_q;

  // Flush strobes last exactly one cycle and register reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_flush_q <= 1'b0;
      rx_flush_q <= 1'b0;
    end else begin
      tx_flush_q <= wr_lo && wb_adr_i == uac_pkg::OFS_TXFLUSH
                    && wb_dat_i[uac_pkg::FLUSH_BIT];
      rx_flush_q <= wr_lo && wb_adr_i == uac_pkg::OFS_RXFLUSH
                    && wb_dat_i[uac_pkg::FLUSH_BIT];
    end
  end

  assign tx_flush_o = tx_flush_q;
  assign rx_flush_o = rx_flush_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_flush_q) begin
      tx_cnt_q <= 8'h00;
    end else begin
      case ({tx_push_i && tx_cnt_q != TX_DEPTH, tx_pop_i && tx_cnt_q != 8'h00})
        2'b10:   tx_cnt_q <= tx_cnt_q + 8'h01;
        2'b01:   tx_cnt_q <= tx_cnt_q - 8'h01;
        default: tx_cnt_q <= tx_cnt_q;
      endcase
    end
  end

  assign rx_drop = rx_push_i && rx_cnt_q == RX_DEPTH && !rx_pop_i;
  assign rx_drop_o = rx_drop;

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush_q) begin
      rx_cnt_q <= 9'h000;
    end else begin
      case ({rx_push_i && !rx_drop, rx_pop_i && rx_cnt_q != 9'h000})
        2'b10:   rx_cnt_q <= rx_cnt_q + 9'h001;
        2'b01:   rx_cnt_q <= rx_cnt_q - 9'h001;
        default: rx_cnt_q <= rx_cnt_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush_q || rx_push_i) begin
      idle_cnt_q <= 2'h0;
    end else if (char_tick_i && rx_cnt_q != 9'h000 && idle_cnt_q != uac_pkg::IDLE_CHARS) begin
      idle_cnt_q <= idle_cnt_q + 2'h1;
    end
  end

  assign pkt_size = acm_q ? uac_pkg::PKT_FULL_ACM : uac_pkg::PKT_FULL;

  // Immediate forward when low latency is on
  // Otherwise hold for a full packet or idle timeout
  assign rx_forward_o = rx_cnt_q != 9'h000
                        && (fwd_q || rx_cnt_q >= pkt_size
                            || idle_cnt_q == uac_pkg::IDLE_CHARS);

  // Pin muxes are registered so the pins never glitch on a loop change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pin_q <= 1'b1;
      rx_ser_q <= 1'b1;
      cts_q    <= 1'b0;
      dsr_q    <= 1'b0;
    end else begin
      tx_pin_q <= loop_q[uac_pkg::LOOP_TXRX_BIT] ? 1'b1 : tx_serial_i;
      rx_ser_q <= loop_q[uac_pkg::LOOP_TXRX_BIT] ? tx_serial_i : pins_s[2];
      cts_q    <= loop_q[uac_pkg::LOOP_RTS_BIT] ? rts_i : pins_s[1];
      dsr_q    <= loop_q[uac_pkg::LOOP_DTR_BIT] ? dtr_i : pins_s[0];
    end
  end

  assign tx_pin_o    = tx_pin_q;
  assign rx_serial_o = rx_ser_q;
  assign cts_o       = cts_q;
  assign dsr_o       = dsr_q;

  assign capture   = state_q == uac_pkg::UAC_IDLE && pend_q;
  assign byte_done = state_q == uac_pkg::UAC_SEND && note_ready_i;

  assign live = {ring_i, break_i, dsr_q, carrier_i};

  always_comb begin
    status_w = {9'h000, ovr_q, par_q, frm_q, live};
    if (fmt_q) begin
      status_w[14:12] = gpio_s[5:3];
      status_w[11]    = gpio_s[0];
      status_w[9:8]   = gpio_s[2:1];
    end
  end

  // Error flags are latched until a packet carries them; a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_q <= 1'b0;
      par_q <= 1'b0;
      frm_q <= 1'b0;
    end else begin
      ovr_q <= rx_drop       | (ovr_q & ~capture);
      par_q <= parity_err_i  | (par_q & ~capture);
      frm_q <= framing_err_i | (frm_q & ~capture);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_prev_q <= 6'h00;
      live_prev_q <= 4'h0;
    end else begin
      gpio_prev_q <= gpio_s;
      live_prev_q <= live;
    end
  end

  assign trigger = |((gpio_s ^ gpio_prev_q) & ~gpmask_q)
                   | (live != live_prev_q)
                   | rx_drop | parity_err_i | framing_err_i;

  // Changes seen while a packet is out coalesce into one more packet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= trigger | (pend_q & ~capture);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= uac_pkg::UAC_IDLE;
    end else begin
      case (state_q)
        uac_pkg::UAC_IDLE: if (capture) state_q <= uac_pkg::UAC_SEND;
        uac_pkg::UAC_SEND: begin
          if (byte_done && idx_q == uac_pkg::NOTE_LAST_IDX) begin
            state_q <= uac_pkg::UAC_IDLE;
          end
        end
        default: state_q <= uac_pkg::UAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_q <= 80'h0;
      idx_q <= 4'h0;
    end else if (capture) begin
      pkt_q <= {status_w, uac_pkg::NOTE_LENGTH, uac_pkg::NOTE_INDEX,
                uac_pkg::NOTE_VALUE, uac_pkg::NOTE_CODE, uac_pkg::NOTE_REQ_TYPE};
      idx_q <= 4'h0;
    end else if (byte_done) begin
      pkt_q <= {8'h00, pkt_q[79:8]};
      idx_q <= idx_q + 4'h1;
    end
  end

  assign note_data_o  = pkt_q[7:0];
  assign note_valid_o = state_q == uac_pkg::UAC_SEND;
  assign note_last_o  = state_q == uac_pkg::UAC_SEND && idx_q == uac_pkg::NOTE_LAST_IDX;

endmodule // uac_top

// ===== sim/uac_top_monitor.sv
module uac_top_monitor #(
  parameter logic [7:0] TX_DEPTH = 8'h80,
  parameter logic [8:0] RX_DEPTH = 9'h100
) (
  input wire logic        clk_i,          // Core clock
  input wire logic        rst_i,          // Sync reset
  input wire logic        wb_cyc_i,       // Bus cycle
  input wire logic        wb_stb_i,       // Bus strobe
  input wire logic        wb_we_i,        // Write enable
  input wire logic [7:0]  wb_adr_i,       // Byte address
  input wire logic [3:0]  wb_sel_i,       // Byte lanes
  input wire logic [31:0] wb_dat_i,       // Write data
  input wire logic        wb_ack_o,       // Acknowledge
  input wire logic        rx_push_i,      // Char received
  input wire logic        rx_pop_i,       // Char to host
  input wire logic        tx_flush_o,     // Tx empty pulse
  input wire logic        rx_flush_o,     // Rx empty pulse
  input wire logic        rx_drop_o,      // Char dropped
  input wire logic        tx_serial_i,    // Transmitter bit
  input wire logic        tx_pin_o,       // Transmit pin
  input wire logic        rx_serial_o,    // Receiver input
  input wire logic        rts_i,          // RTS level
  input wire logic        cts_o,          // CTS out
  input wire logic [7:0]  pullup_en_o,    // Pull-ups
  input wire logic [7:0]  pulldown_en_o,  // Pull-downs
  input wire logic [7:0]  note_data_o,    // Note byte
  input wire logic        note_valid_o,   // Byte valid
  input wire logic        note_last_o,    // Last byte
  input wire logic        note_ready_i    // Byte taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       wr_ack;
  logic [8:0] lvl_q;
  logic [3:0] idx_q;
  logic [1:0] loop_q;

  // A write lands on the edge where ack is seen
  assign wr_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

  // Pushing and popping in one cycle is left unmodelled; the bench never does it
  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush_o) lvl_q <= 9'h000;
    else if (rx_push_i && !rx_pop_i && lvl_q != RX_DEPTH) lvl_q <= lvl_q + 9'h001;
    else if (rx_pop_i && !rx_push_i && lvl_q != 9'h000) lvl_q <= lvl_q - 9'h001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) idx_q <= 4'h0;
    else if (note_valid_o && note_ready_i) idx_q <= note_last_o ? 4'h0 : idx_q + 4'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) loop_q <= 2'b00;
    else if (wr_ack && wb_adr_i == uac_pkg::OFS_LOOP) loop_q <= wb_dat_i[1:0];
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pullup_copy: assert property (wr_ack && wb_adr_i == uac_pkg::OFS_PULLUP
    |-> ##2 pullup_en_o == $past(wb_dat_i[7:0], 2)) else $error("pull-up enables wrong");
  a_pulldown_copy: assert property (wr_ack && wb_adr_i == uac_pkg::OFS_PULLDN
    |-> ##2 pulldown_en_o == $past(wb_dat_i[7:0], 2)) else $error("pull-down enables wrong");
  a_loop_tx_idle: assert property (loop_q[0] && $past(loop_q[0])
    |-> tx_pin_o && rx_serial_o == $past(tx_serial_i)) else $error("tx loop path wrong");
  a_loop_rts_cts: assert property (loop_q[1] && $past(loop_q[1])
    |-> cts_o == $past(rts_i)) else $error("rts loop path wrong");
  a_tx_flush_pulse: assert property (wr_ack && wb_adr_i == uac_pkg::OFS_TXFLUSH
    && wb_dat_i[0] |=> tx_flush_o ##1 !tx_flush_o) else $error("tx flush pulse wrong");
  a_rx_flush_pulse: assert property (wr_ack && wb_adr_i == uac_pkg::OFS_RXFLUSH
    && wb_dat_i[0] |=> rx_flush_o ##1 !rx_flush_o) else $error("rx flush pulse wrong");
  a_drop_overrun: assert property (rx_push_i && !rx_pop_i
    |-> rx_drop_o == (lvl_q == RX_DEPTH)) else $error("drop flag wrong");
  a_header_bytes: assert property (note_valid_o && idx_q < 4'h2
    |-> note_data_o == (idx_q == 4'h0 ? 8'hA1 : 8'h20)) else $error("header byte wrong");
  a_zero_fields: assert property (note_valid_o && idx_q inside {[4'h2:4'h5]}
    |-> note_data_o == 8'h00) else $error("value or index byte wrong");
  a_length_last: assert property (note_valid_o |-> note_last_o == (idx_q == 4'h9)
    && (idx_q != 4'h6 || note_data_o == 8'h02) && (idx_q != 4'h7 || note_data_o == 8'h00))
    else $error("length or last flag wrong");
  a_byte_held: assert property (note_valid_o && !note_ready_i
    |=> note_valid_o && $stable(note_data_o)) else $error("byte not held");
endmodule // uac_top_monitor

// ===== sim/uac_host_model.sv
module uac_host_model (
  input  wire logic        clk_i,         // Core clock
  input  wire logic        rst_i,         // Sync reset
  input  wire logic [7:0]  note_data_i,   // Note byte
  input  wire logic        note_valid_i,  // Byte valid
  input  wire logic        note_last_i,   // Last byte
  input  wire logic        slow_i,        // Stall every other cycle
  output logic             note_ready_o,  // Byte taken
  output logic      [79:0] pkt_o,         // Last packet, byte 0 low
  output logic      [3:0]  pkt_len_o,     // Index of last byte
  output int               pkt_count_o    // Packets taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [79:0] buf_q;
  logic [3:0]  n_q;

  // Host polling is bursty, so ready may drop regardless of valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      note_ready_o <= 1'b0;
      n_q <= 4'h0;
      pkt_count_o <= 0;
    end else begin
      note_ready_o <= slow_i ? !note_ready_o : 1'b1;
      if (note_valid_i && note_ready_o) begin
        buf_q[{n_q, 3'b000} +: 8] <= note_data_i;
        n_q <= note_last_i ? 4'h0 : n_q + 4'h1;
        if (note_last_i) begin
          pkt_o <= {note_data_i, buf_q[71:0]};
          pkt_len_o <= n_q;
          pkt_count_o <= pkt_count_o + 1;
        end
      end
    end
  end
endmodule // uac_host_model

// ===== sim/uac_top_bench.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end

module uac_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TX_DEPTH = 8'h04;
  localparam logic [8:0] RX_DEPTH = 9'h040;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, pullup_en_o, pulldown_en_o, note_data_o;
  logic [3:0]  wb_sel_i, pkt_len;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        tx_push_i, tx_pop_i, rx_push_i, rx_pop_i, tx_flush_o, rx_flush_o, rx_drop_o;
  logic        char_tick_i, rx_forward_o, tx_serial_i, tx_pin_o, rx_pin_i, rx_serial_o;
  logic        rts_i, dtr_i, cts_pin_i, dsr_pin_i, cts_o, dsr_o, ring_i, break_i, carrier_i;
  logic        parity_err_i, framing_err_i, wide_mode_o, note_valid_o, note_last_o;
  logic        note_ready_i, slow;
  logic [23:0] baud_rate_i;
  logic [5:0]  gpio_pin_i;
  logic [79:0] pkt;
  int          pkt_count, n0, bad_count = 0, check_count = 0;

  always #2 clk_i = ~clk_i;

  uac_top #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) i_uac_top (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .tx_push_i, .tx_pop_i, .rx_push_i, .rx_pop_i, .tx_flush_o, .rx_flush_o, .rx_drop_o,
    .baud_rate_i, .char_tick_i, .rx_forward_o, .tx_serial_i, .tx_pin_o, .rx_pin_i,
    .rx_serial_o, .rts_i, .dtr_i, .cts_pin_i, .dsr_pin_i, .cts_o, .dsr_o, .gpio_pin_i,
    .ring_i, .break_i, .carrier_i, .parity_err_i, .framing_err_i, .pullup_en_o,
    .pulldown_en_o, .wide_mode_o, .note_data_o, .note_valid_o, .note_last_o, .note_ready_i);

  uac_host_model i_uac_host_model (.clk_i, .rst_i, .note_data_i(note_data_o),
    .note_valid_i(note_valid_o), .note_last_i(note_last_o), .slow_i(slow),
    .note_ready_o(note_ready_i), .pkt_o(pkt), .pkt_len_o(pkt_len), .pkt_count_o(pkt_count));

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic pushes(input logic tx, input int n);
    @(posedge clk_i);
    tx_push_i <= tx;
    rx_push_i <= !tx;
    repeat (n) @(posedge clk_i);
    tx_push_i <= 1'b0;
    rx_push_i <= 1'b0;
  endtask

  // Earlier triggers must drain first, or packets coalesce
  task automatic quiet();
    repeat (60) @(posedge clk_i);
    n0 = pkt_count;
  endtask

  task automatic pkt_chk(input logic [15:0] s);
    repeat (200) begin
      if (pkt_count != n0) break;
      @(posedge clk_i);
    end
    `CHK(pkt, {s, 16'h0002, 32'h0000_0000, 8'h20, 8'hA1})
    `CHK(pkt_len, 4'h9)
  endtask

  task automatic print_verdict();
    $display("Mismatches %0d in %0d checks", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, tx_push_i, tx_pop_i, rx_push_i, rx_pop_i} = 7'h00;
    {char_tick_i, rts_i, dtr_i, cts_pin_i, dsr_pin_i, ring_i, break_i, carrier_i} = 8'h00;
    {parity_err_i, framing_err_i} = 2'b00;
    {wb_adr_i, wb_dat_i, wb_sel_i, gpio_pin_i} = '0;
    {tx_serial_i, rx_pin_i, slow} = 3'b111;
    baud_rate_i = 24'h00_A001;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(uac_pkg::OFS_FMT, 32'h0000_0000);
    rdc(uac_pkg::OFS_LOOP, 32'h0000_0000);
    rdc(uac_pkg::OFS_FWD, 32'h0000_0000);
    rdc(uac_pkg::OFS_GPMASK, 32'h0000_003F);
    rdc(8'h40, 32'h0000_0000);
    wb(1'b1, uac_pkg::OFS_PULLUP, 32'h0000_00A5);
    wb(1'b1, uac_pkg::OFS_PULLDN, 32'h0000_005A);
    rdc(uac_pkg::OFS_PULLDN, 32'h0000_005A);
    `CHK({pullup_en_o, pulldown_en_o}, 16'hA55A)
    wb(1'b1, uac_pkg::OFS_WIDE, 32'h0000_0001);
    rdc(uac_pkg::OFS_WIDE, 32'h0000_0001);
    `CHK(wide_mode_o, 1'b1)
    pushes(1'b1, 5);
    rdc(uac_pkg::OFS_TXLEVEL, 32'h0000_0004);
    @(posedge clk_i);
    tx_pop_i <= 1'b1;
    @(posedge clk_i);
    tx_pop_i <= 1'b0;
    rdc(uac_pkg::OFS_TXLEVEL, 32'h0000_0003);
    wb(1'b1, uac_pkg::OFS_TXFLUSH, 32'h0000_0001);
    rdc(uac_pkg::OFS_TXFLUSH, 32'h0000_0000);
    rdc(uac_pkg::OFS_TXLEVEL, 32'h0000_0000);
    quiet();
    ring_i <= 1'b1;
    pkt_chk(16'h0008);
    // Full-packet threshold is 63 with the driver bit set, 64 without
    wb(1'b1, uac_pkg::OFS_DRIVER, 32'h0000_0001);
    pushes(1'b0, 62);
    #1 `CHK(rx_forward_o, 1'b0)
    pushes(1'b0, 1);
    #1 `CHK(rx_forward_o, 1'b1)
    wb(1'b1, uac_pkg::OFS_DRIVER, 32'h0000_0000);
    #1 `CHK(rx_forward_o, 1'b0)
    pushes(1'b0, 1);
    #1 `CHK(rx_forward_o, 1'b1)
    rdc(uac_pkg::OFS_RXLEVEL, 32'h0000_0040);
    quiet();
    {rx_push_i, parity_err_i, framing_err_i} <= 3'b111;
    @(posedge clk_i);
    {rx_push_i, parity_err_i, framing_err_i} <= 3'b000;
    pkt_chk(16'h0078);
    rdc(uac_pkg::OFS_RXLEVEL, 32'h0000_0040);
    wb(1'b1, uac_pkg::OFS_RXFLUSH, 32'h0000_0001);
    rdc(uac_pkg::OFS_RXLEVEL, 32'h0000_0000);
    pushes(1'b0, 1);
    @(posedge clk_i);
    char_tick_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    char_tick_i <= 1'b0;
    #1 `CHK(rx_forward_o, 1'b0)
    @(posedge clk_i);
    char_tick_i <= 1'b1;
    @(posedge clk_i);
    char_tick_i <= 1'b0;
    #1 `CHK(rx_forward_o, 1'b1)
    @(posedge clk_i);
    rx_pop_i <= 1'b1;
    @(posedge clk_i);
    rx_pop_i <= 1'b0;
    wb(1'b1, uac_pkg::OFS_FWD, 32'h0000_0001);
    pushes(1'b0, 1);
    #1 `CHK(rx_forward_o, 1'b1)
    wb(1'b1, uac_pkg::OFS_FWD, 32'h0000_0000);
    rdc(uac_pkg::OFS_FWD, 32'h0000_0000);
    baud_rate_i <= 24'h00_A000;
    rdc(uac_pkg::OFS_FWD, 32'h0000_0001);
    `CHK(rx_forward_o, 1'b1)
    tx_serial_i <= 1'b0;
    rdc(uac_pkg::OFS_LOOP, 32'h0000_0000);
    `CHK({tx_pin_o, rx_serial_o}, 2'b01)
    wb(1'b1, uac_pkg::OFS_LOOP, 32'h0000_0007);
    {rts_i, dtr_i} <= 2'b11;
    rdc(uac_pkg::OFS_LOOP, 32'h0000_0007);
    `CHK({tx_pin_o, rx_serial_o, cts_o, dsr_o}, 4'b1011)
    wb(1'b1, uac_pkg::OFS_LOOP, 32'h0000_0000);
    repeat (6) @(posedge clk_i);
    `CHK({tx_pin_o, rx_serial_o, cts_o, dsr_o}, 4'b0100)
    // Carrier goes up early so its own packet drains before the pin test
    carrier_i <= 1'b1;
    quiet();
    slow <= 1'b0;
    // Count is kept from before the masked change, so any packet from it shows
    gpio_pin_i <= 6'b00_0010;
    repeat (60) @(posedge clk_i);
    wb(1'b1, uac_pkg::OFS_FMT, 32'h0000_0001);
    wb(1'b1, uac_pkg::OFS_GPMASK, 32'h0000_0000);
    `CHK(pkt_count == n0, 1'b1)
    gpio_pin_i <= 6'b10_1011;
    pkt_chk(16'h5909);
    print_verdict();
  end

  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
endmodule // uac_top_bench

bind uac_top uac_top_monitor #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) i_uac_top_monitor (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .rx_push_i, .rx_pop_i, .tx_flush_o, .rx_flush_o, .rx_drop_o, .tx_serial_i, .tx_pin_o,
  .rx_serial_o, .rts_i, .cts_o, .pullup_en_o, .pulldown_en_o, .note_data_o, .note_valid_o,
  .note_last_o, .note_ready_i);
